//--- blbd_top.sv
// Purpose: Execute stage for negative-test, not-equal and breakpoint instructions
// Assumes: Register file reads arrive with the instruction on the same clock
// Notes:   One-cycle latency from issue to registered results
`timescale 1ns/1ps
`default_nettype none
module blbd_top
#(
    parameter int XLEN = 64
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              issue_valid,
    input  wire logic [31:0]       instr,
    input  wire logic [XLEN-1:0]   branch_pc,
    input  wire logic [XLEN-1:0]   src_a_value,
    input  wire logic [XLEN-1:0]   src_b_value,
    input  wire logic              likely_enable,
    output logic                   result_valid,
    output logic                   redirect,
    output logic [XLEN-1:0]        target_pc,
    output logic                   nullify_slot,
    output logic                   link_we,
    output logic [4:0]             link_idx,
    output logic [XLEN-1:0]        link_value,
    output logic                   break_exc,
    output logic                   resv_exc,
    output logic [4:0]             src_a_idx,
    output logic [4:0]             src_b_idx
);
    // Elaboration-time refusal: the sign-extended offset needs at least a word of width
    if (XLEN < 32)
    begin : g_xlen_check
        $error("XLEN too small for branch offset arithmetic");
    end

    blbd_pkg::blbd_op_t op;
    logic              is_likely;
    logic              is_link;
    logic              is_neg;
    logic              cond;
    logic              legal;
    logic [XLEN-1:0]   offs_ext;
    logic              valid_reg,  valid_next;
    logic              redir_reg,  redir_next;
    logic [XLEN-1:0]   tgt_reg,    tgt_next;
    logic              null_reg,   null_next;
    logic              lwe_reg,    lwe_next;
    logic [XLEN-1:0]   lval_reg,   lval_next;
    logic              brk_reg,    brk_next;
    logic              resv_reg,   resv_next;

    blbd_decode u_dec
    (
        .instr (instr),
        .op    (op)
    );

    // Register indices go straight to the register file read ports
    assign src_a_idx = instr[blbd_pkg::SRCA_HI:blbd_pkg::SRCA_LO];
    assign src_b_idx = instr[blbd_pkg::SRCB_HI:blbd_pkg::SRCB_LO];

    // Shift offset by two, then sign-extend to full width
    assign offs_ext = {{(XLEN-18){instr[blbd_pkg::OFFS_HI]}}, instr[blbd_pkg::OFFS_HI:0], 2'b00};

    // Opcode attributes and condition evaluation
    always_comb
    begin
        is_likely = (op == blbd_pkg::BLBD_OP_NEG_LL) || (op == blbd_pkg::BLBD_OP_NEG_LK)
                 || (op == blbd_pkg::BLBD_OP_NE_LK);
        is_link   = (op == blbd_pkg::BLBD_OP_NEG_LINK) || (op == blbd_pkg::BLBD_OP_NEG_LL);
        is_neg    = is_link || (op == blbd_pkg::BLBD_OP_NEG_LK);
        if (is_neg)
            cond = src_a_value[XLEN-1];
        else
            cond = (src_a_value != src_b_value);
        // Likely forms without the enabling level are trapped, not executed
        legal = !is_likely || likely_enable;
    end

    // Next-state computation; register 31 as tested source is undefined, no check
    always_comb
    begin
        valid_next = 1'b0;
        redir_next = 1'b0;
        tgt_next   = tgt_reg;
        null_next  = 1'b0;
        lwe_next   = 1'b0;
        lval_next  = lval_reg;
        brk_next   = 1'b0;
        resv_next  = 1'b0;
        if (issue_valid && op != blbd_pkg::BLBD_OP_NONE)
        begin
            valid_next = 1'b1;
            if (op == blbd_pkg::BLBD_OP_BREAK)
                brk_next = 1'b1;
            else if (!legal)
                resv_next = 1'b1;
            else
            begin
                // Target relative to the delay slot, so fetch runs the slot first
                tgt_next   = branch_pc + XLEN'(blbd_pkg::DSLOT_OFFSET) + offs_ext;
                redir_next = cond;
                null_next  = is_likely && !cond;
                lwe_next   = is_link;
                lval_next  = branch_pc + XLEN'(blbd_pkg::LINK_OFFSET);
            end
        end
    end

    // State registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            valid_reg <= 1'b0;
            redir_reg <= 1'b0;
            tgt_reg   <= '0;
            null_reg  <= 1'b0;
            lwe_reg   <= 1'b0;
            lval_reg  <= '0;
            brk_reg   <= 1'b0;
            resv_reg  <= 1'b0;
        end
        else
        begin
            valid_reg <= valid_next;
            redir_reg <= redir_next;
            tgt_reg   <= tgt_next;
            null_reg  <= null_next;
            lwe_reg   <= lwe_next;
            lval_reg  <= lval_next;
            brk_reg   <= brk_next;
            resv_reg  <= resv_next;
        end
    end

    assign result_valid = valid_reg;
    assign redirect     = redir_reg;
    assign target_pc    = tgt_reg;
    assign nullify_slot = null_reg;
    assign link_we      = lwe_reg;
    assign link_idx     = blbd_pkg::LINK_REG_IDX;
    assign link_value   = lval_reg;
    assign break_exc    = brk_reg;
    assign resv_exc     = resv_reg;

    sequence s_issue_link;
        issue_valid && (op == blbd_pkg::BLBD_OP_NEG_LINK) ;
    endsequence

    AST_TARGET: assert property (@(posedge sys_clk) disable iff (rst)
        issue_valid && legal && op != blbd_pkg::BLBD_OP_NONE && op != blbd_pkg::BLBD_OP_BREAK
        |=> target_pc == $past(branch_pc) + 64'(4) + $past(offs_ext))
        else $error("branch target wrong");
    AST_NEG_COND: assert property (@(posedge sys_clk) disable iff (rst)
        issue_valid && op == blbd_pkg::BLBD_OP_NEG_LINK |=> redirect == $past(src_a_value[XLEN-1]))
        else $error("sign test wrong");
    AST_LINK: assert property (@(posedge sys_clk) disable iff (rst)
        s_issue_link |=> link_we && link_value == $past(branch_pc) + 64'(8) && link_idx == 5'h1f)
        else $error("link write wrong");
    AST_NULL: assert property (@(posedge sys_clk) disable iff (rst)
        nullify_slot |-> !redirect && result_valid)
        else $error("nullify while taken");
    AST_PLAIN_NONULL: assert property (@(posedge sys_clk) disable iff (rst)
        issue_valid && (op == blbd_pkg::BLBD_OP_NE || op == blbd_pkg::BLBD_OP_NEG_LINK) |=> !nullify_slot)
        else $error("plain form nullified");
    AST_NE_COND: assert property (@(posedge sys_clk) disable iff (rst)
        issue_valid && op == blbd_pkg::BLBD_OP_NE |=> redirect == ($past(src_a_value) != $past(src_b_value)))
        else $error("not-equal test wrong");
    AST_BREAK: assert property (@(posedge sys_clk) disable iff (rst)
        issue_valid && instr[31:26] == 6'h00 && instr[5:0] == 6'h0d |=> break_exc && !redirect && !link_we)
        else $error("breakpoint missed");
    AST_RESV: assert property (@(posedge sys_clk) disable iff (rst)
        issue_valid && !likely_enable && op == blbd_pkg::BLBD_OP_NE_LK |=> resv_exc && !redirect)
        else $error("reserved trap missed");

    // Raw-field views of the issued word, so these checks do not lean on the decoder
    sequence s_run_neg_link_likely;
        issue_valid && likely_enable && instr[31:26] == 6'h01 && instr[20:16] == 5'h12;
    endsequence
    sequence s_run_neg_likely;
        issue_valid && likely_enable && instr[31:26] == 6'h01 && instr[20:16] == 5'h02;
    endsequence
    sequence s_run_ne_likely;
        issue_valid && likely_enable && instr[31:26] == 6'h15;
    endsequence
    sequence s_ignored_register_immediate_class;
        issue_valid && instr[31:26] == 6'h01 && instr[20:16] == 5'h00;
    endsequence

    // Likely forms: only the linking one writes link, taken or not; the slot dies only when not taken
    AST_LINK_LIKELY: assert property (@(posedge sys_clk) disable iff (rst)
        s_run_neg_link_likely |=> link_we && link_value == $past(branch_pc) + XLEN'(8)
            && redirect == $past(src_a_value[XLEN-1]) && nullify_slot == !$past(src_a_value[XLEN-1]))
        else $error("linking likely branch wrong");
    AST_NEG_LIKELY: assert property (@(posedge sys_clk) disable iff (rst)
        s_run_neg_likely |=> !link_we && redirect == $past(src_a_value[XLEN-1])
            && nullify_slot == !$past(src_a_value[XLEN-1]))
        else $error("negative likely branch wrong");
    AST_NE_LIKELY: assert property (@(posedge sys_clk) disable iff (rst)
        s_run_ne_likely |=> !link_we && redirect == ($past(src_a_value) != $past(src_b_value))
            && nullify_slot == ($past(src_a_value) == $past(src_b_value)))
        else $error("not-equal likely branch wrong");
    AST_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
        s_ignored_register_immediate_class |=> !result_valid)
        else $error("unknown subcode executed");
    AST_NE_NOLINK: assert property (@(posedge sys_clk) disable iff (rst)
        issue_valid && instr[31:26] == 6'h05 |=> !link_we)
        else $error("non-linking form wrote link");

    // Outcome pulses must not contradict each other in one cycle
    AST_REDIRECT_CLEAN: assert property (@(posedge sys_clk) disable iff (rst)
        redirect |-> result_valid && !break_exc && !resv_exc && !nullify_slot)
        else $error("redirect alongside a trap");
    AST_BREAK_ALONE: assert property (@(posedge sys_clk) disable iff (rst)
        break_exc |-> result_valid && !nullify_slot && !resv_exc && !link_we)
        else $error("breakpoint mixed with branch effects");
    AST_RESV_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
        resv_exc |-> result_valid && !redirect && !nullify_slot && !link_we)
        else $error("reserved trap with branch effects");
    AST_PLAIN_NOTRAP: assert property (@(posedge sys_clk) disable iff (rst)
        issue_valid && (instr[31:26] == 6'h05 || (instr[31:26] == 6'h01 && instr[20:16] == 5'h10))
        |=> !resv_exc)
        else $error("plain form trapped");
endmodule
`default_nettype wire

//--- blbd_pkg.sv
// Purpose: Constants for the branch, link and breakpoint decoder
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes:   Field positions, opcodes and link offset live here
// Behaviour
// - Target is sign-extended offset shifted by two plus delay-slot address.
// - Sign-test branches are taken when the tested register's top bit is one.
// - Linking forms write PC plus 8 into register 31, taken or not.
// - A taken branch runs the delay slot first, then goes to the target.
// - Likely forms nullify the delay slot when not taken; plain forms never do.
// - Not-equal branches are taken when the two source registers differ anywhere.
// - Class 000001 subcode 10000 is negative-link; 10010 is its likely form.
// - Class 000001 subcode 00010 is the non-linking negative likely branch.
// - Opcode 000101 is not-equal, 010101 not-equal likely, two sources plus offset.
// - Opcode 000000 function 001101 raises a breakpoint at once, unconditionally.
// - The 20-bit breakpoint code field is ignored by hardware.
package blbd_pkg;
    localparam int OPC_HI      = 31;
    localparam int OPC_LO      = 26;
    localparam int SRCA_HI     = 25;
    localparam int SRCA_LO     = 21;
    localparam int SRCB_HI     = 20;
    localparam int SRCB_LO     = 16;
    localparam int OFFS_HI     = 15;
    localparam int FUNC_HI     = 5;
    localparam logic [5:0] OPC_SPECIAL   = 6'h00;
    localparam logic [5:0] OPC_REG_IMM   = 6'h01;
    localparam logic [5:0] OPC_NOT_EQ    = 6'h05;
    localparam logic [5:0] OPC_NOT_EQ_LK = 6'h15;
    localparam logic [5:0] FUNC_BREAK    = 6'h0d;
    localparam logic [4:0] SUB_NEG_LK    = 5'h02;
    localparam logic [4:0] SUB_NEG_LINK  = 5'h10;
    localparam logic [4:0] SUB_NEG_LNKLK = 5'h12;
    localparam logic [4:0] LINK_REG_IDX  = 5'h1f;
    localparam int         LINK_OFFSET   = 8;
    localparam int         DSLOT_OFFSET  = 4;
    typedef enum logic [2:0]
    {
        BLBD_OP_NONE     = 3'b000,
        BLBD_OP_NEG_LINK = 3'b001,
        BLBD_OP_NEG_LL   = 3'b010,
        BLBD_OP_NEG_LK   = 3'b011,
        BLBD_OP_NE       = 3'b100,
        BLBD_OP_NE_LK    = 3'b101,
        BLBD_OP_BREAK    = 3'b110
    } blbd_op_t;
endpackage

//--- blbd_decode.sv
// Purpose: Combinational opcode classifier
// Assumes: Instruction word is stable while valid
// Notes:   Pure decode, no state
`timescale 1ns/1ps
`default_nettype none
module blbd_decode
(
    input  wire logic [31:0]       instr,
    output var blbd_pkg::blbd_op_t op
);
    logic [5:0] opc;
    logic [4:0] sub;
    logic [5:0] func;
    // Field slicing; breakpoint code bits are simply never looked at
    assign opc  = instr[blbd_pkg::OPC_HI:blbd_pkg::OPC_LO];
    assign sub  = instr[blbd_pkg::SRCB_HI:blbd_pkg::SRCB_LO];
    assign func = instr[blbd_pkg::FUNC_HI:0];
    // Classify the instruction word
    always_comb
    begin
        op = blbd_pkg::BLBD_OP_NONE;
        case (opc)
            blbd_pkg::OPC_REG_IMM:
            begin
                case (sub)
                    blbd_pkg::SUB_NEG_LINK:  op = blbd_pkg::BLBD_OP_NEG_LINK;
                    blbd_pkg::SUB_NEG_LNKLK: op = blbd_pkg::BLBD_OP_NEG_LL;
                    blbd_pkg::SUB_NEG_LK:    op = blbd_pkg::BLBD_OP_NEG_LK;
                    default:                 op = blbd_pkg::BLBD_OP_NONE;
                endcase
            end
            blbd_pkg::OPC_NOT_EQ:    op = blbd_pkg::BLBD_OP_NE;
            blbd_pkg::OPC_NOT_EQ_LK: op = blbd_pkg::BLBD_OP_NE_LK;
            blbd_pkg::OPC_SPECIAL:
            begin
                if (func == blbd_pkg::FUNC_BREAK)
                    op = blbd_pkg::BLBD_OP_BREAK;
                else
                    op = blbd_pkg::BLBD_OP_NONE;
            end
            default: op = blbd_pkg::BLBD_OP_NONE;
        endcase
    end
endmodule
`default_nettype wire

//--- blbd_fetch_model.sv
// Purpose: Fetch sequencer stand-in that follows the decoder's outcome pulses
// Assumes: One outcome per cycle at most, pulses last a single cycle
// Notes:   Keeps the target aside until the delay slot has gone by
`timescale 1ns/1ps
`default_nettype none
module blbd_fetch_model
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        redirect,
    input  wire logic        nullify_slot,
    input  wire logic [63:0] target_pc,
    output logic [63:0]      resume_pc,
    output logic             slot_squashed
);
    // Slot runs first, so the target is only parked here for the next fetch
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            resume_pc     <= 64'h0;
            slot_squashed <= 1'b0;
        end
        else
        begin
            if (redirect)
                resume_pc <= target_pc;
            slot_squashed <= nullify_slot;
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
// Purpose: Random self-checking bench for the branch and breakpoint decoder
// Assumes: Outcome one cycle after the issuing edge
// Notes:   Expected outcomes wait in a queue until their cycle comes
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {logic v, r, n, l, b, x, br; logic [63:0] t, lv;} blbd_exp_t;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        issue_valid = 1'b0;
    logic        likely_enable = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [63:0] branch_pc = 64'h0;
    logic [63:0] src_a_value = 64'h0;
    logic [63:0] src_b_value = 64'h0;
    logic        result_valid, redirect, nullify_slot, link_we, break_exc, resv_exc, slot_squashed;
    logic [63:0] target_pc, link_value, resume_pc;
    logic [4:0]  link_idx, src_a_idx, src_b_idx;
    logic [5:0]  opc_tab [0:6] = '{6'h01, 6'h01, 6'h01, 6'h05, 6'h15, 6'h00, 6'h01};
    logic [4:0]  sub_tab [0:6] = '{5'h10, 5'h12, 5'h02, 5'h00, 5'h00, 5'h00, 5'h00};
    blbd_exp_t   exq [$];
    blbd_exp_t   ep = '0;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;

    blbd_top i_blbd_top (.sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid), .instr(instr),
        .branch_pc(branch_pc), .src_a_value(src_a_value), .src_b_value(src_b_value),
        .likely_enable(likely_enable), .result_valid(result_valid), .redirect(redirect),
        .target_pc(target_pc), .nullify_slot(nullify_slot), .link_we(link_we), .link_idx(link_idx),
        .link_value(link_value), .break_exc(break_exc), .resv_exc(resv_exc), .src_a_idx(src_a_idx),
        .src_b_idx(src_b_idx));
    blbd_fetch_model i_blbd_fetch_model (.sys_clk(sys_clk), .rst(rst), .redirect(redirect),
        .nullify_slot(nullify_slot), .target_pc(target_pc), .resume_pc(resume_pc),
        .slot_squashed(slot_squashed));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Random issue of one of six known kinds or an ignored word
    task automatic drive_one();
        int k;
        logic [31:0] w;
        logic [63:0] a, b, pc;
        logic iv, le, cond, lik, rec;
        blbd_exp_t x;
        k = $urandom_range(6);
        a = {$urandom(), $urandom()};
        b = $urandom_range(1) ? a : a ^ (64'h1 << $urandom_range(63));
        pc = {$urandom(), $urandom()} & ~64'h3;
        iv = ($urandom_range(7) != 0);
        le = 1'($urandom_range(1));
        w = $urandom();
        w[25:21] = 5'($urandom_range(30));
        w[31:26] = opc_tab[k];
        if (k < 3 || k == 6)
            w[20:16] = sub_tab[k];
        if (k == 5)
            w[5:0] = 6'h0d;
        cond = (k < 3) ? a[63] : (a != b);
        lik = (k == 1 || k == 2 || k == 4);
        rec = iv && k != 6;
        x.x = rec && lik && !le;
        x.v = rec; // Trapped likely forms still report an executed word
        x.b = rec && k == 5;
        x.br = rec && !x.x && k != 5;
        x.r = x.br && cond;
        x.n = x.br && lik && !cond;
        x.l = x.br && k < 2;
        x.t = pc + 64'h4 + {{46{w[15]}}, w[15:0], 2'b00};
        x.lv = pc + 64'h8;
        exq.push_back(x);
        issue_valid <= iv;
        instr <= w;
        branch_pc <= pc;
        src_a_value <= a;
        src_b_value <= b;
        likely_enable <= le;
    endtask

    // Compare the outcome of the issue taken at this edge
    task automatic check_prev();
        blbd_exp_t e;
        chk("src_a_idx", src_a_idx, instr[25:21]);
        chk("src_b_idx", src_b_idx, instr[20:16]);
        if (exq.size() < 2)
            return;
        e = exq.pop_front();
        if (ep.r)
            chk("resume_pc", resume_pc, ep.t);
        chk("slot_squashed", slot_squashed, ep.n);
        ep = e;
        chk("result_valid", result_valid, e.v);
        chk("redirect", redirect, e.r);
        chk("nullify_slot", nullify_slot, e.n);
        chk("link_we", link_we, e.l);
        chk("break_exc", break_exc, e.b);
        chk("resv_exc", resv_exc, e.x);
        chk("link_idx", link_idx, 5'h1f);
        if (e.br)
            chk("target_pc", target_pc, e.t);
        if (e.l)
            chk("link_value", link_value, e.lv);
    endtask

    always #2.5 sys_clk = ~sys_clk;

    // Hang guard well above the planned run length
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            failures = failures + 1;
            end_sim();
        end
    end

    initial
    begin
        void'($urandom(55));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (800)
        begin
            @(posedge sys_clk);
            drive_one();
            #1 check_prev();
        end
        $display("test random issue done");
        // Reset in mid-run with an issue still pending
        // Issue is dropped so no stale word is taken once reset lets go
        @(posedge sys_clk);
        rst <= 1'b1;
        issue_valid <= 1'b0;
        @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk("pulses after reset", {result_valid, redirect, nullify_slot, link_we, break_exc, resv_exc}, 6'h00);
        chk("target_pc after reset", target_pc, 64'h0);
        chk("link_value after reset", link_value, 64'h0);
        exq.delete();
        ep = '0;
        repeat (100)
        begin
            @(posedge sys_clk);
            drive_one();
            #1 check_prev();
        end
        $display("test reset in mid-run done");
        end_sim();
    end
endmodule
`default_nettype wire
